// ---- rtl/aau_pkg.sv ----
// Shared types and constants for the accumulator arithmetic unit
package aau_pkg;
  // ==========================================================
  // Widths
  localparam int ACC_W = 32;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 16;
  localparam int DIV_W = 50;
  localparam int BCD_DIGITS = 8;
  localparam int BIN_W = 27;
  localparam int STEP_DIGITS = 4;
  // ==========================================================
  // Float layout and constants
  localparam int FP_MANT_W = 23;
  localparam int FP_EXP_LSB = 23;
  localparam int FP_SIGN = 31;
  localparam logic [7:0] FP_EXP_MAX = 8'hFF;
  localparam logic [9:0] FP_BIAS = 10'h07F;
  localparam logic [9:0] FP_EXP_TOP = 10'h0FF;
  localparam int FP_SHIFT = 25;
  // ==========================================================
  // Reset values and the largest BCD digit
  localparam logic [ACC_W-1:0] ACC_RST = 32'h0000_0000;
  localparam logic [3:0] BCD_NINE = 4'h9;
  // ==========================================================
  // Operations
  typedef enum logic [2:0] {
    OP_BCD_DIV_DBL = 3'h0,
    OP_REAL_DIV = 3'h1,
    OP_BCD_INC = 3'h2,
    OP_BCD_DEC = 3'h3,
    OP_BIN_ADD_S = 3'h4,
    OP_BIN_ADD_D = 3'h5,
    OP_BIN_SUB_S = 3'h6
  } aau_op_t;
  typedef struct packed {
    aau_op_t op;
    logic use_imm;
    logic use_ptr;
    logic [ADDR_W-1:0] addr;
    logic [ACC_W-1:0] imm;
  } aau_cmd_t;
  typedef struct packed {
    logic zero_result_flag;
    logic negative_result_flag;
    logic invalid_pointer_flag;
    logic invalid_float_flag;
    logic sign_overflow_flag;
    logic float_underflow_flag;
    logic non_decimal_digit_flag;
    logic carry16_flag;
    logic carry32_flag;
  } aau_flags_t;
  localparam aau_flags_t FLAGS_RST = 9'h000;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_PTR = 6'h02,
    ST_LO = 6'h04,
    ST_HI = 6'h08,
    ST_EXEC = 6'h10,
    ST_DIV = 6'h20
  } aau_state_t;
endpackage

// ---- rtl/aau_divider.sv ----
// Restoring binary divider, one quotient bit per clock
`timescale 1ns/1ns
module aau_divider #(
  parameter int W = 50
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic start,
  input wire logic [W-1:0] dividend,
  input wire logic [W-1:0] divisor,
  output logic [W-1:0] quotient,
  output logic [W-1:0] remainder,
  output logic done
);
  localparam int CW = $clog2(W + 1);
  generate
    if (W < 2) begin : g_bad_w
      $error("aau_divider needs W of at least 2");
    end
  endgenerate
  logic [W-1:0] quo_ff;
  logic [W-1:0] rem_ff;
  logic [W-1:0] div_ff;
  logic [CW-1:0] cnt_ff;
  logic run_ff;
  logic done_ff;
  logic [W:0] trial;
  logic ge;
  assign trial = {rem_ff, quo_ff[W-1]};
  assign ge = trial >= {1'b0, div_ff};
  always_ff @(posedge clock) begin
    if (!resetn) begin
      quo_ff <= '0;
      rem_ff <= '0;
      div_ff <= '0;
      cnt_ff <= '0;
      run_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (start) begin
        quo_ff <= dividend;
        rem_ff <= '0;
        div_ff <= divisor;
        cnt_ff <= CW'(W);
        run_ff <= 1'b1;
      end else if (run_ff) begin
        rem_ff <= ge ? W'(trial - {1'b0, div_ff}) : trial[W-1:0];
        quo_ff <= {quo_ff[W-2:0], ge};
        cnt_ff <= cnt_ff - 1'b1;
        if (cnt_ff == CW'(1)) begin
          run_ff <= 1'b0;
          done_ff <= 1'b1;
        end
      end
    end
  end
  assign quotient = quo_ff;
  assign remainder = rem_ff;
  assign done = done_ff;
endmodule

// ---- rtl/aau_bcd_conv.sv ----
// Binary to packed BCD converter, shift and add three
`timescale 1ns/1ns
module aau_bcd_conv #(
  parameter int BW = 27,
  parameter int DIGITS = 8
) (
  input wire logic [BW-1:0] bin,
  output logic [4*DIGITS-1:0] bcd
);
  generate
    if (BW < 1 || DIGITS < 1) begin : g_bad
      $error("aau_bcd_conv needs positive widths");
    end
  endgenerate
  always_comb begin
    logic [4*DIGITS-1:0] t;
    t = '0;
    for (int i = BW - 1; i >= 0; i--) begin
      for (int d = 0; d < DIGITS; d++) begin
        if (t[4*d +: 4] > 4'h4) begin
          t[4*d +: 4] = t[4*d +: 4] + 4'h3;
        end
      end
      t = {t[4*DIGITS-2:0], bin[i]};
    end
    bcd = t;
  end
endmodule

// ---- rtl/aau_top.sv ----
// Accumulator arithmetic unit: BCD, binary and real operations with status flags
//
// Summary of operation
// (RULE1) BCD double divide uses two memory words only
// (RULE2) Quotient to accumulator, remainder to stack top
// (RULE3) Zero flag follows accumulator result being zero
// (RULE4) Negative flag set for negative divide/add result
// (RULE5) Non-decimal nibble sets non-BCD flag
// (RULE6) Flags change only when an operation drives them
// (RULE7) Real divide by immediate or memory float
// (RULE8) Bad pointer target sets invalid-pointer flag
// (RULE9) Non-number float operand sets invalid-float flag
// (RULE10) Real divide underflow sets underflow flag
// (RULE11) BCD increment adds one, writes word back
// (RULE12) BCD decrement subtracts one, writes word back
// (RULE13) Single add: low half plus 16-bit operand
// (RULE14) Carry out of bit 15 sets carry16
// (RULE15) Carry out of bit 31 sets carry32
// (RULE16) Wrong signed sign bit sets overflow flag
// (RULE17) Double add: accumulator plus 32-bit operand
// (RULE18) Single subtract: accumulator minus 16-bit operand; code subtracts from the low half and clears the upper half
// (RULE19) Divide by zero leaves accumulator, stack unchanged
`timescale 1ns/1ns
module aau_top import aau_pkg::*; #(
  parameter int MEM_WORDS = 4096
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire aau_cmd_t cmd,
  output logic cmd_ready,
  output logic cmd_refused,
  output logic done,
  output logic mem_rd,
  output logic mem_wr,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [WORD_W-1:0] mem_wdata,
  input wire logic [WORD_W-1:0] mem_rdata,
  input wire logic mem_ack,
  output logic [ACC_W-1:0] acc,
  output logic [ACC_W-1:0] stack_top,
  output aau_flags_t flags
);
  generate
    if (MEM_WORDS < 1 || MEM_WORDS > 65536) begin : g_bad_mem
      $error("aau_top MEM_WORDS must be 1 to 65536");
    end
  endgenerate
  // ==========================================================
  // Helpers
  function automatic logic bcd_ok(input logic [ACC_W-1:0] v);
    logic ok;
    ok = 1'b1;
    for (int d = 0; d < BCD_DIGITS; d++) begin
      if (v[4*d +: 4] > BCD_NINE) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  function automatic logic [BIN_W-1:0] bcd2bin(input logic [ACC_W-1:0] v);
    logic [BIN_W-1:0] r;
    r = '0;
    for (int d = BCD_DIGITS - 1; d >= 0; d--) begin
      r = (r << 3) + (r << 1) + {{(BIN_W-4){1'b0}}, v[4*d +: 4]};
    end
    return r;
  endfunction

  // Wraps 9999 to 0000 and back, as a counter digit would
  function automatic logic [WORD_W-1:0] bcd_step(input logic [WORD_W-1:0] v, input logic down);
    logic [WORD_W-1:0] r;
    logic c;
    logic [3:0] n;
    r = v;
    c = 1'b1;
    for (int d = 0; d < STEP_DIGITS; d++) begin
      n = v[4*d +: 4];
      if (c) begin
        if (!down) begin
          c = (n == BCD_NINE);
          r[4*d +: 4] = c ? 4'h0 : n + 4'h1;
        end else begin
          c = (n == 4'h0);
          r[4*d +: 4] = c ? BCD_NINE : n - 4'h1;
        end
      end
    end
    return r;
  endfunction

  // ==========================================================
  // State
  aau_state_t state_ff;
  aau_state_t nxt_state;
  aau_cmd_t cmd_ff;
  logic [ACC_W-1:0] opnd_ff;
  logic [ACC_W-1:0] acc_ff;
  logic [ACC_W-1:0] stack_ff;
  aau_flags_t flags_ff;
  logic ready_ff;
  logic refused_ff;
  logic done_ff;
  logic mem_rd_ff;
  logic mem_wr_ff;
  logic [ADDR_W-1:0] mem_addr_ff;
  logic [WORD_W-1:0] mem_wdata_ff;

  logic accept;
  logic refuse;
  logic ptr_bad;
  logic two_words;
  logic is_div;
  logic div_done;
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_r;
  logic [ACC_W-1:0] q_bcd;
  logic [ACC_W-1:0] r_bcd;

  assign accept = cmd_valid && ready_ff;
  // (RULE1) no immediate divisor
  assign refuse = cmd.use_imm && (cmd.op == OP_BCD_DIV_DBL || cmd.op == OP_BCD_INC
                  || cmd.op == OP_BCD_DEC);
  // (RULE8) pointer target range check
  assign ptr_bad = {16'h0000, mem_rdata} >= 32'(MEM_WORDS);
  assign two_words = cmd_ff.op == OP_BCD_DIV_DBL || cmd_ff.op == OP_REAL_DIV
                     || cmd_ff.op == OP_BIN_ADD_D;
  assign is_div = cmd_ff.op == OP_BCD_DIV_DBL || cmd_ff.op == OP_REAL_DIV;

  // ==========================================================
  // Execution results
  logic run_div;
  logic fin;
  logic wr_back;
  logic [ACC_W-1:0] nxt_acc;
  logic [ACC_W-1:0] nxt_stack;
  aau_flags_t nxt_flags;
  logic [WORD_W-1:0] nxt_wdata;
  logic [DIV_W-1:0] div_a;
  logic [DIV_W-1:0] div_b;
  logic [16:0] sum17;
  logic [32:0] sum33;
  logic [15:0] dif16;
  logic [7:0] ea;
  logic [7:0] eb;
  logic [9:0] e10;
  logic [FP_MANT_W-1:0] mq;
  logic fsign;

  assign ea = acc_ff[FP_EXP_LSB +: 8];
  assign eb = opnd_ff[FP_EXP_LSB +: 8];
  assign fsign = acc_ff[FP_SIGN] ^ opnd_ff[FP_SIGN];
  assign sum17 = {1'b0, acc_ff[15:0]} + {1'b0, opnd_ff[15:0]};
  assign sum33 = {1'b0, acc_ff} + {1'b0, opnd_ff};
  assign dif16 = acc_ff[15:0] - opnd_ff[15:0];
  assign e10 = {2'b00, ea} - {2'b00, eb} + FP_BIAS - {9'h000, ~div_q[FP_SHIFT]};
  assign mq = div_q[FP_SHIFT] ? div_q[FP_SHIFT-1:2] : div_q[FP_SHIFT-2:1];

  always_comb begin
    if (cmd_ff.op == OP_REAL_DIV) begin
      div_a = {1'b0, 1'b1, acc_ff[FP_MANT_W-1:0], {FP_SHIFT{1'b0}}};
      div_b = {{(DIV_W-FP_MANT_W-1){1'b0}}, 1'b1, opnd_ff[FP_MANT_W-1:0]};
    end else begin
      div_a = {{(DIV_W-BIN_W){1'b0}}, bcd2bin(acc_ff)};
      div_b = {{(DIV_W-BIN_W){1'b0}}, bcd2bin(opnd_ff)};
    end
  end

  always_comb begin
    nxt_acc = acc_ff;
    nxt_stack = stack_ff;
    nxt_flags = flags_ff;
    // (RULE8) valid pointer clears at finish
    nxt_flags.invalid_pointer_flag &= cmd_ff.use_imm || !cmd_ff.use_ptr;
    nxt_wdata = bcd_step(opnd_ff[15:0], cmd_ff.op == OP_BCD_DEC);
    run_div = 1'b0;
    wr_back = 1'b0;
    case (cmd_ff.op)
      OP_BIN_ADD_S: begin
        // (RULE13) low half plus word
        nxt_acc = {15'h0000, sum17};
        // (RULE14) carry out of bit 15
        nxt_flags.carry16_flag = sum17[16];
        // (RULE15) no carry past 32 bits here
        nxt_flags.carry32_flag = 1'b0;
        // (RULE16) signed 16-bit overflow
        nxt_flags.sign_overflow_flag = (acc_ff[15] == opnd_ff[15]) && (sum17[15] != acc_ff[15]);
      end
      OP_BIN_ADD_D: begin
        // (RULE17) full width add
        nxt_acc = sum33[31:0];
        // (RULE15) carry out of bit 31
        nxt_flags.carry32_flag = sum33[32];
        // (RULE16) signed 32-bit overflow
        nxt_flags.sign_overflow_flag = (acc_ff[31] == opnd_ff[31]) && (sum33[31] != acc_ff[31]);
      end
      OP_BIN_SUB_S: begin
        // (RULE18) low half minus word
        nxt_acc = {16'h0000, dif16};
        // (RULE16) signed subtract overflow
        nxt_flags.sign_overflow_flag = (acc_ff[15] != opnd_ff[15]) && (dif16[15] != acc_ff[15]);
      end
      OP_BCD_INC, OP_BCD_DEC: begin
        // (RULE5) bad digit blocks the write
        nxt_flags.non_decimal_digit_flag = !bcd_ok({16'h0000, opnd_ff[15:0]});
        // (RULE11) (RULE12) write back stepped value
        wr_back = !nxt_flags.non_decimal_digit_flag;
        // (RULE3) zero on stepped result
        nxt_flags.zero_result_flag = wr_back && (nxt_wdata == 16'h0000);
      end
      OP_BCD_DIV_DBL: begin
        if (state_ff == ST_EXEC) begin
          // (RULE5) both operands checked
          nxt_flags.non_decimal_digit_flag = !bcd_ok(acc_ff) || !bcd_ok(opnd_ff);
          // (RULE19) zero divisor skips
          run_div = !nxt_flags.non_decimal_digit_flag && (opnd_ff != ACC_RST);
        end else begin
          // (RULE2) quotient and remainder
          nxt_flags.non_decimal_digit_flag = 1'b0;
          nxt_acc = q_bcd;
          nxt_stack = r_bcd;
        end
      end
      OP_REAL_DIV: begin
        nxt_flags.invalid_float_flag = 1'b0;
        nxt_flags.float_underflow_flag = 1'b0;
        if (state_ff == ST_EXEC) begin
          // (RULE9) infinity or NaN operand
          nxt_flags.invalid_float_flag = (ea == FP_EXP_MAX) || (eb == FP_EXP_MAX);
          if (!nxt_flags.invalid_float_flag && eb != 8'h00) begin
            // (RULE7) zero dividend short cut
            if (ea == 8'h00) begin
              nxt_acc = ACC_RST;
            end else begin
              run_div = 1'b1;
            end
          end
        end else if (e10[9] || e10 == 10'h000) begin
          // (RULE10) underflow flushes to zero
          nxt_flags.float_underflow_flag = 1'b1;
          nxt_acc = ACC_RST;
        end else if (e10 >= FP_EXP_TOP) begin
          // Overflow leaves an infinity, which is not a usable number
          nxt_flags.invalid_float_flag = 1'b1;
          nxt_acc = {fsign, FP_EXP_MAX, {FP_MANT_W{1'b0}}};
        end else begin
          // (RULE7) truncated quotient
          nxt_acc = {fsign, e10[7:0], mq};
        end
      end
      default: nxt_acc = acc_ff;
    endcase
    if (cmd_ff.op != OP_BCD_INC && cmd_ff.op != OP_BCD_DEC) begin
      // (RULE3) zero flag from accumulator
      nxt_flags.zero_result_flag = (nxt_acc == ACC_RST);
      // (RULE4) negative flag from sign bit
      nxt_flags.negative_result_flag = nxt_acc[31];
    end
  end

  assign fin = (state_ff == ST_EXEC && !run_div) || (state_ff == ST_DIV && div_done);

  // ==========================================================
  // Sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (accept && !refuse) begin
          nxt_state = cmd.use_imm ? ST_EXEC : (cmd.use_ptr ? ST_PTR : ST_LO);
        end
      end
      ST_PTR: begin
        if (mem_ack) begin
          nxt_state = ptr_bad ? ST_IDLE : ST_LO;
        end
      end
      ST_LO: begin
        if (mem_ack) begin
          nxt_state = two_words ? ST_HI : ST_EXEC;
        end
      end
      ST_HI: begin
        if (mem_ack) begin
          nxt_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        nxt_state = run_div ? ST_DIV : ST_IDLE;
      end
      ST_DIV: begin
        if (div_done) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_ff <= ST_IDLE;
      cmd_ff <= '0;
      opnd_ff <= ACC_RST;
    end else begin
      state_ff <= nxt_state;
      if (accept) begin
        cmd_ff <= cmd;
        opnd_ff <= cmd.imm;
        if (cmd.op == OP_BIN_ADD_S || cmd.op == OP_BIN_SUB_S) begin
          opnd_ff <= {16'h0000, cmd.imm[15:0]};
        end
      end
      if (state_ff == ST_PTR && mem_ack) begin
        cmd_ff.addr <= mem_rdata;
      end
      if (state_ff == ST_LO && mem_ack) begin
        opnd_ff <= {16'h0000, mem_rdata};
      end
      if (state_ff == ST_HI && mem_ack) begin
        opnd_ff[31:16] <= mem_rdata;
      end
    end
  end

  // ==========================================================
  // Data memory requests
  always_ff @(posedge clock) begin
    if (!resetn) begin
      mem_rd_ff <= 1'b0;
      mem_wr_ff <= 1'b0;
      mem_addr_ff <= '0;
      mem_wdata_ff <= '0;
    end else begin
      mem_rd_ff <= 1'b0;
      mem_wr_ff <= 1'b0;
      if (state_ff == ST_IDLE && accept && !refuse && !cmd.use_imm) begin
        mem_rd_ff <= 1'b1;
        mem_addr_ff <= cmd.addr;
      end
      if (state_ff == ST_PTR && mem_ack && !ptr_bad) begin
        mem_rd_ff <= 1'b1;
        mem_addr_ff <= mem_rdata;
      end
      if (state_ff == ST_LO && mem_ack && two_words) begin
        mem_rd_ff <= 1'b1;
        mem_addr_ff <= cmd_ff.addr + 16'h0001;
      end
      // (RULE11) (RULE12) same word written back
      if (state_ff == ST_EXEC && wr_back) begin
        mem_wr_ff <= 1'b1;
        mem_addr_ff <= cmd_ff.addr;
        mem_wdata_ff <= nxt_wdata;
      end
    end
  end

  // ==========================================================
  // Accumulator and stack
  always_ff @(posedge clock) begin
    if (!resetn) begin
      acc_ff <= ACC_RST;
      stack_ff <= ACC_RST;
    end else if (fin) begin
      // (RULE19) unchanged unless computed
      acc_ff <= nxt_acc;
      // (RULE2) remainder pushed to stack top
      stack_ff <= nxt_stack;
    end
  end

  // ==========================================================
  // Status flags
  always_ff @(posedge clock) begin
    if (!resetn) begin
      flags_ff <= FLAGS_RST;
    end else if (state_ff == ST_PTR && mem_ack && ptr_bad) begin
      // (RULE8) bad target ends the command
      flags_ff.invalid_pointer_flag <= 1'b1;
    end else if (fin) begin
      // (RULE6) untouched flags hold
      flags_ff <= nxt_flags;
    end
  end

  // ==========================================================
  // Handshake
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ready_ff <= 1'b1;
      refused_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      refused_ff <= 1'b0;
      done_ff <= 1'b0;
      if (accept) begin
        // (RULE1) immediate divisor refused
        refused_ff <= refuse;
        done_ff <= refuse;
        ready_ff <= refuse;
      end
      if (fin || (state_ff == ST_PTR && mem_ack && ptr_bad)) begin
        done_ff <= 1'b1;
        ready_ff <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Shared divider and BCD converters
  aau_divider #(.W(DIV_W)) u_div (
    .clock(clock),
    .resetn(resetn),
    .start(state_ff == ST_EXEC && run_div),
    .dividend(div_a),
    .divisor(div_b),
    .quotient(div_q),
    .remainder(div_r),
    .done(div_done)
  );

  aau_bcd_conv #(.BW(BIN_W), .DIGITS(BCD_DIGITS)) u_q_conv (
    .bin(div_q[BIN_W-1:0]),
    .bcd(q_bcd)
  );

  aau_bcd_conv #(.BW(BIN_W), .DIGITS(BCD_DIGITS)) u_r_conv (
    .bin(div_r[BIN_W-1:0]),
    .bcd(r_bcd)
  );

  assign cmd_ready = ready_ff;
  assign cmd_refused = refused_ff;
  assign done = done_ff;
  assign mem_rd = mem_rd_ff;
  assign mem_wr = mem_wr_ff;
  assign mem_addr = mem_addr_ff;
  assign mem_wdata = mem_wdata_ff;
  assign acc = acc_ff;
  assign stack_top = stack_ff;
  assign flags = flags_ff;
endmodule

// ---- sim/aau_mem_model.sv ----
// Data memory partner model with a settable read latency
`timescale 1ns/1ns
module aau_mem_model import aau_pkg::*; (
  input wire logic clock,
  input wire logic [3:0] lat,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [WORD_W-1:0] mem_wdata,
  output logic [WORD_W-1:0] mem_rdata,
  output logic mem_ack
);
  logic [WORD_W-1:0] mem [256];
  logic [WORD_W-1:0] last;
  logic [7:0] ra;
  logic busy;
  int wait_n;
  initial begin
    busy = 1'b0;
    mem_ack = 1'b0;
    last = 16'h0000;
    mem_rdata = 16'hA5A5;
  end
  // Stale read data inverted so it never passes
  always @(posedge clock) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~last;
    if (mem_wr) begin
      mem[mem_addr[7:0]] <= mem_wdata;
    end
    if (mem_rd) begin
      busy <= 1'b1;
      ra <= mem_addr[7:0];
      wait_n <= int'(lat);
    end else if (busy && wait_n > 0) begin
      wait_n <= wait_n - 1;
    end else if (busy) begin
      busy <= 1'b0;
      mem_ack <= 1'b1;
      mem_rdata <= mem[ra];
      last <= mem[ra];
    end
  end
endmodule

// ---- sim/aau_top_props.sv ----
// Port assertions for the accumulator arithmetic unit
`timescale 1ns/1ns
module aau_top_props import aau_pkg::*; #(
  parameter int MEM_WORDS = 4096
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire aau_cmd_t cmd,
  input wire logic cmd_ready,
  input wire logic cmd_refused,
  input wire logic done,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [WORD_W-1:0] mem_wdata,
  input wire logic [WORD_W-1:0] mem_rdata,
  input wire logic mem_ack,
  input wire logic [ACC_W-1:0] acc,
  input wire logic [ACC_W-1:0] stack_top,
  input wire aau_flags_t flags
);
  logic take;
  logic imm_ok;
  aau_op_t op_ff;
  assign take = cmd_valid && cmd_ready;
  assign imm_ok = take && cmd.use_imm;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      op_ff <= OP_BCD_DIV_DBL;
    end else if (take) begin
      op_ff <= cmd.op;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  AST_REFUSE: assert property (
    imm_ok && (cmd.op inside {OP_BCD_DIV_DBL, OP_BCD_INC, OP_BCD_DEC})
    |=> cmd_refused && done && acc == $past(acc)) else $error("immediate not refused");
  AST_ZERO: assert property (
    done && !cmd_refused && !(op_ff inside {OP_BCD_INC, OP_BCD_DEC})
    |-> flags.zero_result_flag == (acc == 32'h0)) else $error("zero flag wrong");
  AST_NEG: assert property (
    done && (op_ff inside {OP_BIN_ADD_S, OP_BIN_ADD_D})
    |-> flags.negative_result_flag == acc[31]) else $error("negative flag wrong");
  AST_FLAGS_HOLD: assert property (
    $changed(flags) |-> done) else $error("flags moved without an operation");
  AST_ADD16: assert property (
    imm_ok && cmd.op == OP_BIN_ADD_S |-> ##2 done
    && acc == {15'h0, {1'b0, $past(acc[15:0], 2)} + {1'b0, $past(cmd.imm[15:0], 2)}})
    else $error("single add result wrong");
  AST_CARRY16: assert property (
    imm_ok && cmd.op == OP_BIN_ADD_S |-> ##2 flags.carry16_flag == acc[16])
    else $error("carry16 wrong");
  AST_ADD32: assert property (
    imm_ok && cmd.op == OP_BIN_ADD_D |-> ##2 done && acc == $past(acc, 2) + $past(cmd.imm, 2))
    else $error("double add result wrong");
  AST_CARRY32: assert property (
    imm_ok && cmd.op == OP_BIN_ADD_D |-> ##2 flags.carry32_flag == (acc < $past(acc, 2)))
    else $error("carry32 wrong");
  AST_SUB16: assert property (
    imm_ok && cmd.op == OP_BIN_SUB_S |-> ##2 done
    && acc == {16'h0, $past(acc[15:0], 2) - $past(cmd.imm[15:0], 2)})
    else $error("single subtract result wrong");
  AST_WRITE: assert property (
    mem_wr |-> done && (op_ff inside {OP_BCD_INC, OP_BCD_DEC}))
    else $error("stray memory write");
endmodule
bind aau_top aau_top_props #(.MEM_WORDS(MEM_WORDS)) u_aau_top_props (.clock(clock),
  .resetn(resetn), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
  .cmd_refused(cmd_refused), .done(done), .mem_rd(mem_rd), .mem_wr(mem_wr),
  .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
  .acc(acc), .stack_top(stack_top), .flags(flags));

// ---- sim/aau_top_bench.sv ----
// Self-checking bench for the accumulator arithmetic unit
`timescale 1ns/1ns
module aau_top_bench import aau_pkg::*; ();
  logic clock, resetn, cmd_valid, cmd_ready, cmd_refused, done, mem_rd, mem_wr, mem_ack;
  logic [3:0] lat;
  logic [15:0] mem_addr, mem_wdata, mem_rdata;
  logic [31:0] acc, stack_top;
  aau_cmd_t cmd;
  aau_flags_t flags;
  int errors, check_count, cycles;
  aau_op_t bops[3] = '{OP_BCD_DIV_DBL, OP_BCD_INC, OP_BCD_DEC};
  aau_op_t iops[4] = '{OP_BCD_INC, OP_BCD_INC, OP_BCD_DEC, OP_BCD_DEC};
  logic [15:0] iin[4] = '{16'h0999, 16'h9999, 16'h0000, 16'h00A0};
  logic [15:0] iout[4] = '{16'h1000, 16'h0000, 16'h9999, 16'h00A0};
  aau_top #(.MEM_WORDS(256)) u_aau_top (.clock(clock), .resetn(resetn),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .cmd_refused(cmd_refused),
    .done(done), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .acc(acc),
    .stack_top(stack_top), .flags(flags));
  aau_mem_model u_aau_mem_model (.clock(clock), .lat(lat), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack));
  initial clock = 1'b0;
  always #20 clock = ~clock;
  // ==========================================
  // Tasks
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Present at the edge after done so commands run back to back
  task automatic run(input aau_op_t op, input logic ui, input logic up,
    input logic [15:0] a, input logic [31:0] im);
    int n;
    n = 0;
    cmd_valid = 1'b1;
    cmd = '{op, ui, up, a, im};
    @(posedge clock);
    #1 cmd_valid = 1'b0;
    while (done !== 1'b1 && n < 200) begin
      @(posedge clock);
      #1 n++;
    end
    if (n >= 200) begin
      errors++;
      $display("BAD done expected 1 seen %b", done);
    end
  endtask
  task automatic set_acc(input logic [31:0] v);
    run(OP_BIN_SUB_S, 1'b1, 1'b0, 16'h0000, {16'h0, acc[15:0]});
    run(OP_BIN_ADD_D, 1'b1, 1'b0, 16'h0000, v);
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles >= 8000) begin
      errors++;
      $display("BAD cycles expected 8000 seen %0d", cycles);
      report_and_stop();
    end
  end
  // ==========================================
  // Sequence
  initial begin
    resetn = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    lat = 4'h0;
    u_aau_mem_model.mem[10] = 16'h9000;
    u_aau_mem_model.mem[20] = 16'h5678;
    u_aau_mem_model.mem[21] = 16'h1234;
    u_aau_mem_model.mem[40] = 16'hFFFF;
    u_aau_mem_model.mem[41] = 16'h0014;
    u_aau_mem_model.mem[50] = 16'h0007;
    u_aau_mem_model.mem[51] = 16'h0000;
    u_aau_mem_model.mem[52] = 16'h0000;
    u_aau_mem_model.mem[53] = 16'h0000;
    u_aau_mem_model.mem[54] = 16'h000A;
    u_aau_mem_model.mem[55] = 16'h0000;
    u_aau_mem_model.mem[60] = 16'h0000;
    u_aau_mem_model.mem[61] = 16'h3F00;
    repeat (8) @(posedge clock);
    #1 resetn = 1'b1;
    run(OP_BIN_ADD_D, 1'b1, 1'b0, 16'h0000, 32'hFFFF_FFFF);
    check("acc", 32'hFFFF_FFFF, acc);
    check("negative", 1'b1, flags.negative_result_flag);
    run(OP_BIN_ADD_D, 1'b1, 1'b0, 16'h0000, 32'h0000_0001);
    check("carry32", 1'b1, flags.carry32_flag);
    check("zero", 1'b1, flags.zero_result_flag);
    check("overflow", 1'b0, flags.sign_overflow_flag);
    run(OP_BIN_ADD_D, 1'b1, 1'b0, 16'h0000, 32'h7FFF_FFFF);
    run(OP_BIN_ADD_D, 1'b1, 1'b0, 16'h0000, 32'h0000_0001);
    check("overflow", 1'b1, flags.sign_overflow_flag);
    run(OP_BIN_ADD_S, 1'b1, 1'b0, 16'h0000, 32'h0000_FFFF);
    check("acc", 32'h0000_FFFF, acc);
    run(OP_BIN_ADD_S, 1'b1, 1'b0, 16'h0000, 32'h0000_0001);
    check("acc", 32'h0001_0000, acc);
    check("carry16", 1'b1, flags.carry16_flag);
    run(OP_BIN_ADD_S, 1'b1, 1'b0, 16'h0000, 32'h0000_7FFF);
    run(OP_BIN_ADD_S, 1'b1, 1'b0, 16'h0000, 32'h0000_0001);
    check("overflow", 1'b1, flags.sign_overflow_flag);
    lat = 4'h3;
    run(OP_BIN_SUB_S, 1'b0, 1'b0, 16'd10, 32'h0);
    check("acc", 32'h0000_F000, acc);
    check("overflow", 1'b0, flags.sign_overflow_flag);
    run(OP_BIN_ADD_D, 1'b0, 1'b0, 16'd20, 32'h0);
    check("acc", 32'h1235_4678, acc);
    run(OP_BIN_ADD_D, 1'b0, 1'b1, 16'd40, 32'h0);
    check("bad pointer", 1'b1, flags.invalid_pointer_flag);
    check("acc", 32'h1235_4678, acc);
    lat = 4'h0;
    run(OP_BIN_ADD_D, 1'b0, 1'b1, 16'd41, 32'h0);
    check("bad pointer", 1'b0, flags.invalid_pointer_flag);
    check("acc", 32'h2469_9CF0, acc);
    foreach (bops[k]) begin
      run(bops[k], 1'b1, 1'b0, 16'd30, 32'h5);
      check("refused", 1'b1, cmd_refused);
      check("acc", 32'h2469_9CF0, acc);
    end
    foreach (iops[k]) begin
      u_aau_mem_model.mem[30] = iin[k];
      run(iops[k], 1'b0, 1'b0, 16'd30, 32'h0);
      check("digit flag", k == 3, flags.non_decimal_digit_flag);
      @(posedge clock);
      #1 check("word", iout[k], u_aau_mem_model.mem[30]);
    end
    set_acc(32'h0000_0100);
    run(OP_BCD_DIV_DBL, 1'b0, 1'b0, 16'd50, 32'h0);
    check("quotient", 32'h0000_0014, acc);
    check("remainder", 32'h0000_0002, stack_top);
    check("digit flag", 1'b0, flags.non_decimal_digit_flag);
    run(OP_BCD_DIV_DBL, 1'b0, 1'b0, 16'd52, 32'h0);
    check("acc", 32'h0000_0014, acc);
    check("stack", 32'h0000_0002, stack_top);
    run(OP_BCD_DIV_DBL, 1'b0, 1'b0, 16'd54, 32'h0);
    check("digit flag", 1'b1, flags.non_decimal_digit_flag);
    set_acc(32'h3F80_0000);
    run(OP_REAL_DIV, 1'b1, 1'b0, 16'h0000, 32'h4000_0000);
    check("acc", 32'h3F00_0000, acc);
    run(OP_REAL_DIV, 1'b0, 1'b0, 16'd60, 32'h0);
    check("acc", 32'h3F80_0000, acc);
    set_acc(32'h0080_0000);
    run(OP_REAL_DIV, 1'b1, 1'b0, 16'h0000, 32'h4000_0000);
    check("underflow", 1'b1, flags.float_underflow_flag);
    check("acc", 32'h0000_0000, acc);
    set_acc(32'h7FC0_0000);
    run(OP_REAL_DIV, 1'b1, 1'b0, 16'h0000, 32'h3F80_0000);
    check("bad float", 1'b1, flags.invalid_float_flag);
    report_and_stop();
  end
endmodule
